// ===== mbi_checker.sv
/*
  Concurrent checks on the pins between host end and device end.
  Assumes the interface signals and the shared static bus type as inputs.
*/
`timescale 1ns/1ps
module mbi_checker #(
  parameter int PHASE_CYC = 2
) (
  // Clock, reset, configuration
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire mbi_pkg::mbi_bus_t bus_type,
  // Host driven
  input wire logic ad_host_oe,
  input wire logic pa_host_oe,
  input wire logic ctrl_in0,
  input wire logic ctrl_in1,
  input wire logic ctrl_in2,
  input wire logic addr_latch_strobe,
  // Device driven
  input wire logic ad_dev_oe,
  input wire logic pa_dev_oe
);
  logic estb;
  logic fetch2;
  logic nonpage;
  logic rd_act;
  logic wr_act;
  logic [3:0] ale_age;
  logic [3:0] next_ale_age;

  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  assign estb = (bus_type == mbi_pkg::MBI_ESTROBE);
  assign fetch2 = (bus_type == mbi_pkg::MBI_MUX3) || (bus_type == mbi_pkg::MBI_PAGE2RD);
  assign nonpage = (bus_type == mbi_pkg::MBI_MUX3) || (bus_type == mbi_pkg::MBI_MUX1RD);
  // Enable strobe hosts use a level enable plus direction
  assign rd_act = estb ? (ctrl_in1 && ctrl_in0) : (!ctrl_in1 || (fetch2 && !ctrl_in2));
  assign wr_act = estb ? (ctrl_in1 && !ctrl_in0) : !ctrl_in0;

  // Saturating age of the last address strobe
  always_comb begin
    next_ale_age = ale_age;
    if (!addr_latch_strobe) begin
      next_ale_age = 4'h0;
    end else if (ale_age != 4'hF) begin
      next_ale_age = ale_age + 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ale_age <= 4'hF;
    end else begin
      ale_age <= next_ale_age;
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_drive_on_read;
    ad_dev_oe |-> rd_act || $past(rd_act);
  endproperty
  a_drive_on_read: assert property (p_drive_on_read)
    else $error("shared pins driven outside a read");

  property p_porta_tristate;
    (bus_type == mbi_pkg::MBI_NONMUX) && pa_dev_oe |-> rd_act || $past(rd_act);
  endproperty
  a_porta_tristate: assert property (p_porta_tristate)
    else $error("port A driven while not accessed");

  property p_nonmux_addr_pins;
    bus_type == mbi_pkg::MBI_NONMUX |-> !ad_dev_oe;
  endproperty
  a_nonmux_addr_pins: assert property (p_nonmux_addr_pins)
    else $error("address pins driven in non-multiplexed mode");

  property p_no_drive_on_write;
    wr_act |-> !ad_dev_oe && !pa_dev_oe;
  endproperty
  a_no_drive_on_write: assert property (p_no_drive_on_write)
    else $error("device drives during a write");

  property p_drive_release;
    $fell(rd_act) |-> ##1 (!ad_dev_oe && !pa_dev_oe);
  endproperty
  a_drive_release: assert property (p_drive_release)
    else $error("device keeps driving after the read ended");

  property p_no_contention;
    !(ad_host_oe && ad_dev_oe);
  endproperty
  a_no_contention: assert property (p_no_contention)
    else $error("host and device drive the shared pins together");

  property p_ale_every_cycle;
    nonpage && $rose(rd_act || wr_act) |-> ale_age <= PHASE_CYC + 1;
  endproperty
  a_ale_every_cycle: assert property (p_ale_every_cycle)
    else $error("non-page cycle without address strobe");

  property p_strobe_bounded;
    $rose(rd_act) |-> ##[1:16] !rd_act;
  endproperty
  a_strobe_bounded: assert property (p_strobe_bounded)
    else $error("read strobe never released");

  property p_one_kind;
    !(rd_act && wr_act);
  endproperty
  a_one_kind: assert property (p_one_kind)
    else $error("read and write strobes active together");

  property p_host_write_data;
    wr_act |-> ((bus_type == mbi_pkg::MBI_NONMUX) ? pa_host_oe : ad_host_oe);
  endproperty
  a_host_write_data: assert property (p_host_write_data)
    else $error("write data not driven on the data lines");
endmodule

// ===== mbi_defines.svh
/*
  Shared constants for the microcontroller bus interface: bus type codes,
  strobe polarities, field positions and reset values.
  Assumes inclusion by bare name from every design file of the block.
*/
`ifndef MBI_DEFINES_SVH
`define MBI_DEFINES_SVH

// ------------------------------------------------------------
// Bus type codes (static configuration)
// ------------------------------------------------------------
`define MBI_BUS_MUX3     3'h0
`define MBI_BUS_MUX1RD   3'h1
`define MBI_BUS_PAGE1RD  3'h2
`define MBI_BUS_PAGE2RD  3'h3
`define MBI_BUS_NONMUX   3'h4
`define MBI_BUS_BURST    3'h5
`define MBI_BUS_ESTROBE  3'h6

// ------------------------------------------------------------
// Widths and field positions
// ------------------------------------------------------------
`define MBI_ADDR_W       20
`define MBI_LOW_MSB      7
`define MBI_HIGH_LSB     8
`define MBI_HIGH_MSB     15
`define MBI_BURST_MSB    11
`define MBI_BURST_LSB    4
`define MBI_NIB_MSB      3
`define MBI_EXT_LSB      16
`define MBI_EXT_MSB      19
`define MBI_PORTD_W      3
`define MBI_PORT_W       8

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define MBI_ZERO8        8'h00
`define MBI_ZERO20       20'h00000
`define MBI_STROBE_IDLE  1'h1

`endif

// ===== mbi_device.sv
/*
  Peripheral end of the microcontroller bus interface: latches address,
  decodes strobes per static bus type, serves an internal byte memory
  and four general ports; drives data pins on selected reads and, in multiplexed modes, port A while dir_a is nonzero.
  Assumes the host end keeps its strobe and address rules; inputs are
  synchronous to clk_sys.
*/
`timescale 1ns/1ps
`include "mbi_defines.svh"
module mbi_device #(
  parameter int MEM_AW = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Static configuration
  input wire mbi_pkg::mbi_bus_t bus_type,
  input wire logic [19:0] sel_base,
  input wire logic [19:0] sel_mask,
  input wire logic [7:0] port_dir_cfg,
  // Pins
  mbi_if.dev bus,
  // User side
  output logic ext_rd_n,
  output logic ext_wr_n,
  output logic [19:0] cur_addr,
  output logic [7:0] portb_out,
  output logic [7:0] portc_out,
  output logic [2:0] portd_out,
  output logic access
);
  initial begin
    if (MEM_AW < 1 || MEM_AW > 16) begin
      $error("MEM_AW out of range");
    end
  end

  localparam int MEM_N = 1 << MEM_AW;

  logic [7:0] mem [MEM_N];
  logic [19:0] lat, next_lat;
  logic [7:0] wd_hold, next_wd_hold;
  logic prev_wr, next_prev_wr;
  logic [7:0] next_portb_out, next_portc_out;
  logic [2:0] next_portd_out;
  logic next_access, next_ext_rd_n, next_ext_wr_n;
  logic [19:0] next_cur_addr;
  logic [7:0] ad_o, next_ad_o, pa_o, next_pa_o;
  logic ad_oe, next_ad_oe, pa_oe, next_pa_oe;
  logic [7:0] dir_a, next_dir_a;

  function automatic logic sel_hit(input logic [19:0] a, input logic [19:0] b,
                                   input logic [19:0] m);
    sel_hit = ((a ^ b) & m) == `MBI_ZERO20;
  endfunction

  // ------------------------------------------------------------
  // Address assembly and strobe decode
  // ------------------------------------------------------------
  logic is_mux, is_page, is_burst, is_es;
  logic rd, wr, sel;
  logic [19:0] addr;
  logic [7:0] wdata;
  always_comb begin
    is_page = bus_type == mbi_pkg::MBI_PAGE1RD || bus_type == mbi_pkg::MBI_PAGE2RD;
    is_burst = bus_type == mbi_pkg::MBI_BURST;
    is_es = bus_type == mbi_pkg::MBI_ESTROBE;
    is_mux = bus_type != mbi_pkg::MBI_NONMUX;
    next_lat = lat;
    if (!bus.addr_latch_strobe && is_mux) begin
      if (is_page) begin
        next_lat[`MBI_HIGH_MSB:`MBI_HIGH_LSB] = bus.host_addr_data_pins;
      end else if (is_burst) begin
        next_lat[`MBI_BURST_MSB:`MBI_BURST_LSB] = bus.host_addr_data_pins;
        next_lat[`MBI_HIGH_MSB:`MBI_HIGH_LSB+4] = bus.pb_host[3:0];
      end else begin
        next_lat[`MBI_LOW_MSB:0] = bus.host_addr_data_pins;
        next_lat[`MBI_HIGH_MSB:`MBI_HIGH_LSB] = bus.pb_host;
      end
      next_lat[`MBI_EXT_LSB] = bus.porta[0];
    end
    // Upper held from the last strobe; low bits live in page and burst modes
    addr = lat;
    if (!is_mux) begin
      addr = {bus.pc_host[3:0], bus.pb_host, bus.host_addr_data_pins};
    end else if (is_page) begin
      addr[`MBI_LOW_MSB:0] = bus.pb_host;
    end else if (is_burst) begin
      addr[`MBI_NIB_MSB:0] = bus.nib_host;
    end
    addr[`MBI_EXT_LSB] = is_mux ? lat[`MBI_EXT_LSB] : bus.pd_host[0];
    wdata = is_mux ? bus.host_addr_data_pins : bus.porta;
    rd = 1'b0;
    wr = 1'b0;
    case (bus_type)
      mbi_pkg::MBI_MUX3, mbi_pkg::MBI_PAGE2RD, mbi_pkg::MBI_BURST: begin
        rd = !bus.ctrl_in1 || !bus.ctrl_in2;
        wr = !bus.ctrl_in0;
      end
      mbi_pkg::MBI_MUX1RD, mbi_pkg::MBI_PAGE1RD, mbi_pkg::MBI_NONMUX: begin
        rd = !bus.ctrl_in1;
        wr = !bus.ctrl_in0;
      end
      mbi_pkg::MBI_ESTROBE: begin
        rd = bus.ctrl_in1 && bus.ctrl_in0;
        wr = bus.ctrl_in1 && !bus.ctrl_in0;
      end
      default: begin
        rd = 1'b0;
        wr = 1'b0;
      end
    endcase
    sel = sel_hit(addr, sel_base, sel_mask);
  end

  // ------------------------------------------------------------
  // Access engine
  // ------------------------------------------------------------
  logic [MEM_AW-1:0] midx;
  always_comb begin
    // Low MEM_AW address bits pick the memory byte
    midx = addr[MEM_AW-1:0];
    // Host releases data with the strobe, so commit from a held copy
    next_wd_hold = wr ? wdata : wd_hold;
    next_prev_wr = wr;
    next_access = sel && (rd || wr);
    next_cur_addr = addr;
    next_ext_rd_n = !(rd && !sel);
    next_ext_wr_n = !(wr && !sel);
    next_portb_out = portb_out;
    next_portc_out = portc_out;
    next_portd_out = portd_out;
    next_dir_a = dir_a;
    // Write takes effect at the end of the strobe
    if (prev_wr && !wr && sel) begin
      case (addr[1:0])
        2'h1: next_portb_out = wd_hold;
        2'h2: next_portc_out = wd_hold;
        2'h3: next_portd_out = wd_hold[`MBI_PORTD_W-1:0];
        default: next_dir_a = wd_hold;
      endcase
    end
    next_ad_o = mem[midx];
    // Driven only while selected and reading
    next_ad_oe = is_mux && rd && sel;
    next_pa_o = is_mux ? portb_out : mem[midx];
    // Port A released unless this device is read in non-multiplexed mode or, in multiplexed modes, dir_a is nonzero
    next_pa_oe = !is_mux && rd && sel;
  end

  always_ff @(posedge clk_sys) begin
    if (prev_wr && !wr && sel) begin
      mem[midx] <= wd_hold;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      lat <= `MBI_ZERO20;
      wd_hold <= `MBI_ZERO8;
      prev_wr <= 1'b0;
      access <= 1'b0;
      cur_addr <= `MBI_ZERO20;
      ext_rd_n <= `MBI_STROBE_IDLE;
      ext_wr_n <= `MBI_STROBE_IDLE;
      portb_out <= `MBI_ZERO8;
      portc_out <= `MBI_ZERO8;
      portd_out <= 3'h0;
      dir_a <= `MBI_ZERO8;
      ad_o <= `MBI_ZERO8;
      ad_oe <= 1'b0;
      pa_o <= `MBI_ZERO8;
      pa_oe <= 1'b0;
    end else begin
      lat <= next_lat;
      wd_hold <= next_wd_hold;
      prev_wr <= next_prev_wr;
      access <= next_access;
      cur_addr <= next_cur_addr;
      ext_rd_n <= next_ext_rd_n;
      ext_wr_n <= next_ext_wr_n;
      portb_out <= next_portb_out;
      portc_out <= next_portc_out;
      portd_out <= next_portd_out;
      dir_a <= next_dir_a;
      ad_o <= next_ad_o;
      ad_oe <= next_ad_oe;
      pa_o <= next_pa_o;
      pa_oe <= next_pa_oe;
    end
  end

  always_comb begin
    // Bus type is a static input, never changed while running
    bus.ad_dev_o = ad_o;
    bus.ad_dev_oe = ad_oe;
    bus.pa_dev_o = pa_o;
    bus.pa_dev_oe = pa_oe | (is_mux & (|dir_a));
  end
endmodule

// ===== mbi_host.sv
/*
  Host processor end: runs one read or write bus cycle per request on
  the configured bus type, driving strobes low-active except the high-active enable of enable strobe mode.
  Assumes static bus_type and a device end on the same interface.
*/
`timescale 1ns/1ps
`include "mbi_defines.svh"
module mbi_host #(
  parameter int PHASE_CYC = 2
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Configuration
  input wire mbi_pkg::mbi_bus_t bus_type,
  // Pins
  mbi_if.host bus,
  // User request
  input wire logic req,
  input wire logic req_write,
  input wire logic req_fetch,
  input wire logic [19:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic busy,
  output logic done,
  output logic [7:0] rdata
);
  initial begin
    if (PHASE_CYC < 1 || PHASE_CYC > 255) begin
      $error("PHASE_CYC out of range");
    end
  end

  typedef enum logic [1:0] {
    MBH_IDLE = 2'h0,
    MBH_ADDR = 2'h1,
    MBH_DATA = 2'h2,
    MBH_END = 2'h3
  } mbh_state_t;

  mbh_state_t state, next_state;
  logic [7:0] cnt, next_cnt;
  logic [19:0] addr, next_addr;
  logic [7:0] wd, next_wd;
  logic wr, next_wr, fe, next_fe;
  logic [15:0] last_hi, next_last_hi;
  logic hi_valid, next_hi_valid;
  logic skip_ale, next_skip_ale;
  logic next_busy, next_done;
  logic [7:0] next_rdata;
  logic is_page, is_burst, is_mux, is_es;

  always_comb begin
    is_page = bus_type == mbi_pkg::MBI_PAGE1RD || bus_type == mbi_pkg::MBI_PAGE2RD;
    is_burst = bus_type == mbi_pkg::MBI_BURST;
    is_es = bus_type == mbi_pkg::MBI_ESTROBE;
    is_mux = bus_type != mbi_pkg::MBI_NONMUX;
  end

  // ------------------------------------------------------------
  // Cycle sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_addr = addr;
    next_wd = wd;
    next_wr = wr;
    next_fe = fe;
    next_last_hi = last_hi;
    next_hi_valid = hi_valid;
    next_skip_ale = skip_ale;
    next_busy = busy;
    next_done = 1'b0;
    next_rdata = rdata;
    case (state)
      MBH_IDLE: begin
        if (req) begin
          next_addr = req_addr;
          next_wd = req_wdata;
          next_wr = req_write;
          next_fe = req_fetch;
          next_busy = 1'b1;
          next_cnt = 8'(PHASE_CYC);
          // Page hit or burst step: no strobe
          next_skip_ale = (is_page || is_burst) && hi_valid &&
                          last_hi == req_addr[19:4];
          next_state = MBH_ADDR;
        end
      end
      MBH_ADDR: begin
        if (cnt == 8'h01) begin
          next_cnt = 8'(PHASE_CYC);
          next_state = MBH_DATA;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      MBH_DATA: begin
        if (cnt == 8'h01) begin
          if (!wr) begin
            next_rdata = is_mux ? bus.host_addr_data_pins : bus.porta;
          end
          next_last_hi = addr[19:4];
          next_hi_valid = 1'b1;
          next_state = MBH_END;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      MBH_END: begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_state = MBH_IDLE;
      end
      default: begin
        next_state = MBH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= MBH_IDLE;
      cnt <= `MBI_ZERO8;
      addr <= `MBI_ZERO20;
      wd <= `MBI_ZERO8;
      wr <= 1'b0;
      fe <= 1'b0;
      last_hi <= 16'h0000;
      hi_valid <= 1'b0;
      skip_ale <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      rdata <= `MBI_ZERO8;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      addr <= next_addr;
      wd <= next_wd;
      wr <= next_wr;
      fe <= next_fe;
      last_hi <= next_last_hi;
      hi_valid <= next_hi_valid;
      skip_ale <= next_skip_ale;
      busy <= next_busy;
      done <= next_done;
      rdata <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  logic in_addr, in_data, rd_act, wr_act;
  always_comb begin
    in_addr = state == MBH_ADDR;
    in_data = state == MBH_DATA;
    rd_act = in_data && !wr;
    wr_act = in_data && wr;
    // Strobe every multiplexed cycle except a page hit or burst step
    bus.addr_latch_strobe = !(in_addr && !skip_ale && is_mux);
    bus.high_byte_enable = 1'b1;
    bus.nib_host = addr[3:0];
    bus.pb_host = 8'h00;
    bus.pc_host = 8'h00;
    bus.pd_host = 3'h0;
    // Port A bit 0 carries address bit 16 in multiplexed modes
    bus.pa_host_o = is_mux ? {7'h00, addr[16]} : wd;
    bus.pa_host_oe = is_mux || wr_act;
    bus.ad_host_oe = 1'b0;
    bus.ad_host_o = addr[7:0];
    bus.ctrl_in0 = `MBI_STROBE_IDLE;
    bus.ctrl_in1 = `MBI_STROBE_IDLE;
    bus.ctrl_in2 = `MBI_STROBE_IDLE;
    if (!is_mux) begin
      // Address on the shared pins, data on port A
      bus.ad_host_oe = busy;
      bus.pb_host = addr[15:8];
      bus.pc_host = {4'h0, addr[19:16]};
    end else if (in_addr) begin
      bus.ad_host_oe = !skip_ale;
      bus.ad_host_o = is_page ? addr[15:8] : (is_burst ? addr[11:4] : addr[7:0]);
    end else if (wr_act) begin
      bus.ad_host_oe = 1'b1;
      bus.ad_host_o = wd;
    end
    if (is_mux && !is_page && !is_burst) begin
      bus.pb_host = addr[15:8];
    end else if (is_page) begin
      bus.pb_host = addr[7:0];
    end else if (is_burst) begin
      bus.pb_host = {4'h0, addr[15:12]};
    end
    // Bit 16 also on port D for the non-multiplexed decode
    bus.pd_host = {2'h0, addr[16]};
    if (is_es) begin
      // Direction on ctrl_in0, enable on ctrl_in1 (high active)
      bus.ctrl_in0 = !wr;
      bus.ctrl_in1 = in_data;
    end else begin
      bus.ctrl_in0 = !wr_act;
      if (bus_type == mbi_pkg::MBI_MUX1RD || bus_type == mbi_pkg::MBI_PAGE1RD) begin
        bus.ctrl_in1 = !rd_act;
      end else if (bus_type == mbi_pkg::MBI_MUX3 || bus_type == mbi_pkg::MBI_PAGE2RD ||
                   bus_type == mbi_pkg::MBI_BURST) begin
        bus.ctrl_in1 = !(rd_act && !fe);
        bus.ctrl_in2 = !(rd_act && fe);
      end else begin
        bus.ctrl_in1 = !rd_act;
      end
    end
  end
endmodule

// ===== mbi_if.sv
/*
  Pin bundle between host processor end and peripheral end.
  Each shared pin carries per-party output and enable; the resolved
  level is formed here (device wins over host, pull-up when none drives).
*/
`timescale 1ns/1ps
`include "mbi_defines.svh"
interface mbi_if;
  // Host driven
  logic [7:0] ad_host_o;
  logic ad_host_oe;
  logic [7:0] pb_host;
  logic [7:0] pc_host;
  logic [2:0] pd_host;
  logic [3:0] nib_host;
  logic ctrl_in0;
  logic ctrl_in1;
  logic ctrl_in2;
  logic addr_latch_strobe;
  logic high_byte_enable;
  // Port A is two-way: data in non-multiplexed mode
  logic [7:0] pa_host_o;
  logic pa_host_oe;
  // Device driven
  logic [7:0] ad_dev_o;
  logic ad_dev_oe;
  logic [7:0] pa_dev_o;
  logic pa_dev_oe;
  // Resolved levels
  logic [7:0] host_addr_data_pins;
  logic [7:0] porta;

  always_comb begin
    host_addr_data_pins = 8'hFF;
    if (ad_host_oe) begin
      host_addr_data_pins = ad_host_o;
    end
    if (ad_dev_oe) begin
      host_addr_data_pins = ad_dev_o;
    end
    porta = 8'hFF;
    if (pa_host_oe) begin
      porta = pa_host_o;
    end
    if (pa_dev_oe) begin
      porta = pa_dev_o;
    end
  end

  modport dev (
    input host_addr_data_pins, porta, pb_host, pc_host, pd_host, nib_host,
    input ctrl_in0, ctrl_in1, ctrl_in2, addr_latch_strobe, high_byte_enable,
    output ad_dev_o, ad_dev_oe, pa_dev_o, pa_dev_oe
  );
  modport host (
    input host_addr_data_pins, porta,
    output ad_host_o, ad_host_oe, pa_host_o, pa_host_oe, pb_host, pc_host,
    output pd_host, nib_host, ctrl_in0, ctrl_in1, ctrl_in2, addr_latch_strobe,
    output high_byte_enable
  );
endinterface

// ===== mbi_pkg.sv
/*
  Types of the microcontroller bus interface.
  Assumes mbi_defines.svh is available on the include path.
*/
`include "mbi_defines.svh"
package mbi_pkg;
  typedef enum logic [2:0] {
    MBI_MUX3 = 3'h0,
    MBI_MUX1RD = 3'h1,
    MBI_PAGE1RD = 3'h2,
    MBI_PAGE2RD = 3'h3,
    MBI_NONMUX = 3'h4,
    MBI_BURST = 3'h5,
    MBI_ESTROBE = 3'h6
  } mbi_bus_t;

  typedef enum logic [1:0] {
    MBI_IDLE = 2'h0,
    MBI_READ = 2'h1,
    MBI_WRITE = 2'h2
  } mbi_cyc_t;
endpackage

// ===== mcu_bus_interface_8bit_test.sv
/*
  Self-checking bench: host end and device end joined by the interface.
  Assumes bus type changes only while reset is held.
*/
`timescale 1ns/1ps
module mcu_bus_interface_8bit_test;
  localparam int PHASE = 2;
  logic clk_sys = 1'b0;
  logic reset_n;
  mbi_pkg::mbi_bus_t bus_type;
  logic [19:0] sel_base;
  logic [19:0] sel_mask;
  logic req;
  logic req_write;
  logic req_fetch;
  logic [19:0] req_addr;
  logic [7:0] req_wdata;
  logic busy;
  logic done;
  logic [7:0] rdata;
  logic ext_rd_n;
  logic ext_wr_n;
  logic access;
  logic [19:0] cur_addr;
  logic [7:0] portb_out;
  logic [7:0] portc_out;
  logic [2:0] portd_out;
  logic seen_acc;
  logic seen_rd;
  logic seen_wr;
  int fails;
  int checks_done;

  always #4 clk_sys = ~clk_sys;

  mbi_if mbi_if_i ();
  mbi_host #(.PHASE_CYC(PHASE)) mbi_host_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .bus_type(bus_type), .bus(mbi_if_i.host), .req(req), .req_write(req_write),
    .req_fetch(req_fetch), .req_addr(req_addr), .req_wdata(req_wdata), .busy(busy),
    .done(done), .rdata(rdata));
  mbi_device #(.MEM_AW(8)) mbi_device_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .bus_type(bus_type), .sel_base(sel_base), .sel_mask(sel_mask),
    .port_dir_cfg(8'h00), .bus(mbi_if_i.dev), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n),
    .cur_addr(cur_addr), .portb_out(portb_out), .portc_out(portc_out),
    .portd_out(portd_out), .access(access));
  mbi_checker #(.PHASE_CYC(PHASE)) mbi_checker_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .bus_type(bus_type), .ad_host_oe(mbi_if_i.ad_host_oe),
    .pa_host_oe(mbi_if_i.pa_host_oe), .ctrl_in0(mbi_if_i.ctrl_in0),
    .ctrl_in1(mbi_if_i.ctrl_in1), .ctrl_in2(mbi_if_i.ctrl_in2),
    .addr_latch_strobe(mbi_if_i.addr_latch_strobe), .ad_dev_oe(mbi_if_i.ad_dev_oe),
    .pa_dev_oe(mbi_if_i.pa_dev_oe));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Bus type is static, so it only changes under reset
  task automatic set_mode(input mbi_pkg::mbi_bus_t m);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    bus_type <= m;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
  endtask

  task automatic bus_cycle(input logic wr, input logic fetch, input logic [19:0] addr,
                           input logic [7:0] wdata);
    int n;
    @(posedge clk_sys);
    req <= 1'b1;
    req_write <= wr;
    req_fetch <= fetch;
    req_addr <= addr;
    req_wdata <= wdata;
    @(posedge clk_sys);
    req <= 1'b0;
    seen_acc = 1'b0;
    seen_rd = 1'b0;
    seen_wr = 1'b0;
    n = 0;
    while (done !== 1'b1) begin
      @(posedge clk_sys);
      #1;
      seen_acc = seen_acc | (access === 1'b1);
      seen_rd = seen_rd | (ext_rd_n === 1'b0);
      seen_wr = seen_wr | (ext_wr_n === 1'b0);
      n++;
      if (n > 40) begin
        fails++;
        $display("Error bus cycle timeout at %h", addr);
        test_done();
      end
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic scen_modes();
    mbi_pkg::mbi_bus_t m;
    logic [7:0] d_even;
    logic [7:0] d_odd;
    for (int i = 0; i < 7; i++) begin
      m = mbi_pkg::mbi_bus_t'(i[2:0]);
      d_even = 8'h30 + 8'(i);
      d_odd = 8'hC5 - 8'(i);
      set_mode(m);
      bus_cycle(1'b1, 1'b0, 20'h00011, 8'h96 ^ d_even);
      check("port b", portb_out, 8'h96 ^ d_even);
      check("write access", seen_acc, 1'b1);
      check("host idle after done", busy, 1'b0);
      bus_cycle(1'b1, 1'b0, 20'h00012, d_even);
      bus_cycle(1'b1, 1'b0, 20'h00013, d_odd);
      check("port c", portc_out, d_even);
      check("port d", portd_out, d_odd[2:0]);
      bus_cycle(1'b0, 1'b0, 20'h00012, 8'h00);
      check("even byte", rdata, d_even);
      check("read access", seen_acc, 1'b1);
      bus_cycle(1'b0, i < 4, 20'h00013, 8'h00);
      check("odd byte", rdata, d_odd);
      check("latched address", cur_addr, 20'h00013);
      bus_cycle(1'b0, 1'b0, 20'h00011, 8'h00);
      check("port b readback", rdata, 8'h96 ^ d_even);
    end
  endtask

  // Bit 16 set lies outside the selected range
  task automatic scen_unselected();
    set_mode(mbi_pkg::MBI_NONMUX);
    bus_cycle(1'b0, 1'b0, 20'h10012, 8'h00);
    check("nonmux far read data", rdata, 8'hFF);
    check("nonmux far access", seen_acc, 1'b0);
    set_mode(mbi_pkg::MBI_PAGE1RD);
    bus_cycle(1'b0, 1'b1, 20'h10012, 8'h00);
    check("page far read data", rdata, 8'hFF);
    check("page far derived read", seen_rd, 1'b1);
    set_mode(mbi_pkg::MBI_ESTROBE);
    bus_cycle(1'b1, 1'b0, 20'h00011, 8'h5A);
    bus_cycle(1'b1, 1'b0, 20'h10011, 8'hA5);
    check("far derived write", seen_wr, 1'b1);
    check("far write access", seen_acc, 1'b0);
    check("port b kept", portb_out, 8'h5A);
  endtask

  initial begin
    reset_n = 1'b0;
    bus_type = mbi_pkg::MBI_MUX3;
    sel_base = 20'h00000;
    sel_mask = 20'hFFF00;
    req = 1'b0;
    req_write = 1'b0;
    req_fetch = 1'b0;
    req_addr = 20'h00000;
    req_wdata = 8'h00;
    fails = 0;
    checks_done = 0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    scen_modes();
    scen_unselected();
    test_done();
  end
endmodule
